// ---- rtl/bqm_pkg.sv ----
package bqm_pkg;

    localparam int BQM_DW      = 32;
    localparam int BQM_ACC_W   = 68;
    localparam int BQM_NCOEF   = 5;
    localparam int BQM_CIDX_W  = 3;
    localparam int BQM_NSEC    = 6;
    localparam int BQM_NLEVEL  = 3;
    localparam int BQM_FRAC    = 31;

    // Coefficient slot order inside one section
    localparam logic [2:0] BQM_N0 = 3'h0;
    localparam logic [2:0] BQM_N1 = 3'h1;
    localparam logic [2:0] BQM_N2 = 3'h2;
    localparam logic [2:0] BQM_D1 = 3'h3;
    localparam logic [2:0] BQM_D2 = 3'h4;

    // Word indices on the register bus (byte address = 4 * index)
    localparam logic [7:0] BQM_W_CTRL     = 8'h00;
    localparam logic [7:0] BQM_W_STATUS   = 8'h01;
    localparam logic [7:0] BQM_W_COEF_LO  = 8'h20;
    localparam logic [7:0] BQM_W_COEF_HI  = 8'h4F;
    localparam logic [7:0] BQM_W_MIX_LO   = 8'h50;
    localparam logic [7:0] BQM_W_MIX_HI   = 8'h53;

    // Control field positions and reset values
    localparam int         BQM_CTRL_ALLOC_LSB = 0;
    localparam int         BQM_CTRL_AVG_LSB   = 2;
    localparam logic [1:0] BQM_ALLOC_RST      = 2'h2;
    localparam logic [1:0] BQM_AVG_RST        = 2'h0;
    localparam logic [1:0] BQM_AVG_SUM        = 2'h1;

    // Native byte-register layout of the six usable sections
    localparam int BQM_SEC_BYTES = 20;
    localparam logic [1:0] BQM_SEC_PAGE  [BQM_NSEC] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
    localparam logic [7:0] BQM_SEC_FIRST [BQM_NSEC] = '{8'h08, 8'h1C, 8'h58, 8'h6C, 8'h30, 8'h44};

    localparam logic [31:0] BQM_UNITY = 32'h7FFFFFFF;
    localparam logic [31:0] BQM_ZERO  = 32'h00000000;
    localparam logic [BQM_NCOEF-1:0][31:0] BQM_BQ_RST =
        {BQM_ZERO, BQM_ZERO, BQM_ZERO, BQM_ZERO, BQM_UNITY};
    localparam logic [3:0][31:0] BQM_MIX_RST = {BQM_UNITY, BQM_ZERO, BQM_ZERO, BQM_UNITY};

    localparam logic signed [BQM_ACC_W-1:0] BQM_ROUND = 68'sh00000000040000000;
    localparam logic signed [BQM_ACC_W-1:0] BQM_SMAX  = 68'sh0000000007FFFFFFF;
    localparam logic signed [BQM_ACC_W-1:0] BQM_SMIN  = 68'shFFFFFFFFF80000000;

    typedef enum logic [1:0] {BQM_ST_IDLE, BQM_ST_FILT} bqm_state_type;

    // Scale a 1.31 accumulator back to a sample, clipping instead of wrapping
    function automatic logic [31:0] bqm_sat(input logic signed [BQM_ACC_W-1:0] acc);
        logic signed [BQM_ACC_W-1:0] sh;
        sh = (acc + BQM_ROUND) >>> BQM_FRAC;
        if (sh > BQM_SMAX)
            return BQM_SMAX[31:0];
        else if (sh < BQM_SMIN)
            return BQM_SMIN[31:0];
        return sh[31:0];
    endfunction

    function automatic logic [31:0] bqm_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        return res;
    endfunction

endpackage

// ---- rtl/bqm_section.sv ----
`timescale 1ns/1ps
module bqm_section
    import bqm_pkg::*;
(
    input  wire logic                  ref_clk_in,
    input  wire logic                  srst_in,
    input  wire logic                  coef_we_in,
    input  wire logic [BQM_CIDX_W-1:0] coef_idx_in,
    input  wire logic [31:0]           coef_data_in,
    output logic      [31:0]           coef_rd_out,
    input  wire logic                  step_in,
    input  wire logic [31:0]           x_in,
    output logic      [31:0]           y_out
);

    typedef struct packed {
        logic [BQM_NCOEF-1:0][31:0] coef;
        logic [31:0]                x1;
        logic [31:0]                x2;
        logic [31:0]                y1;
        logic [31:0]                y2;
    } bqm_sec_state_type;

    bqm_sec_state_type r;
    bqm_sec_state_type next_r;

    always_comb
    begin
        logic signed [63:0]          p0;
        logic signed [63:0]          p1;
        logic signed [63:0]          p2;
        logic signed [63:0]          p3;
        logic signed [63:0]          p4;
        logic signed [BQM_ACC_W-1:0] acc;
        logic        [31:0]          y;
        next_r = r;
        p0 = $signed(r.coef[BQM_N0]) * $signed(x_in);
        p1 = $signed(r.coef[BQM_N1]) * $signed(r.x1);
        p2 = $signed(r.coef[BQM_N2]) * $signed(r.x2);
        p3 = $signed(r.coef[BQM_D1]) * $signed(r.y1);
        p4 = $signed(r.coef[BQM_D2]) * $signed(r.y2);
        acc = BQM_ACC_W'(p0) + (BQM_ACC_W'(p1) <<< 1) + BQM_ACC_W'(p2)
            + (BQM_ACC_W'(p3) <<< 1) + BQM_ACC_W'(p4);
        y = bqm_sat(acc);
        if (coef_we_in && coef_idx_in < BQM_CIDX_W'(BQM_NCOEF))
            next_r.coef[coef_idx_in] = coef_data_in;
        if (step_in)
        begin
            next_r.x1 = x_in;
            next_r.x2 = r.x1;
            next_r.y1 = y;
            next_r.y2 = r.y1;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            r      <= '0;
            r.coef <= BQM_BQ_RST;
        end
        else
            r <= next_r;
    end

    assign y_out       = r.y1;
    assign coef_rd_out = (coef_idx_in < BQM_CIDX_W'(BQM_NCOEF)) ? r.coef[coef_idx_in] : '0;

    default clocking bqm_sec_cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    AST_ALLPASS_UNITY: assert property (
        step_in && !coef_we_in && r.coef == BQM_BQ_RST && (x_in[31:29] == {3{x_in[31]}})
        |=> y_out == $past(x_in))
        else $error("default section does not pass the sample unchanged");

endmodule // bqm_section

// ---- rtl/bqm_top.sv ----
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// How it works
// - At most six filter sections serve the two record channels.
// - Each section is a two-pole two-zero recursive filter, denominator 2^31.
// - Reset coefficients make every section a unity-gain all-pass stage.
// - Section coefficients are 32-bit signed two's complement words.
// - Allocation zero bypasses every section on both channels.
// - Allocation 01: section 1 on channel 1, section 2 on channel 2.
// - Allocation 10, the default: sections 1,5 and 2,6 per channel.
// - Allocation 11: sections 1,5,9 and 2,6,10 per channel.
// - Twenty bytes per section; sections split over coefficient pages 2 and 3.
// - Channel average select 00, the default, keeps channels separate.
// - Channel average select 01 puts half the input sum on both outputs.
// - Mixer acts only while channel average select is zero.
// - Mixer 1 builds output 1 from scaled inputs.
// - Mixer 2 builds output 2 from its own scaled inputs.
// - Mixer coefficients are signed 1.31 fixed point.
// - 0x7FFFFFFF is unity, zero mutes, values between scale.
// - A set sign bit inverts the contribution's polarity.
module bqm_top
    import bqm_pkg::*;
#(
    parameter int ADDR_W = 10
)
(
    input  wire logic              ref_clk_in,
    input  wire logic              srst_in,
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic      [31:0]       avs_readdata_out,
    output logic                   avs_waitrequest_out,
    input  wire logic              smp_valid_in,
    output logic                   smp_ready_out,
    input  wire logic [31:0]       smp_ch1_in,
    input  wire logic [31:0]       smp_ch2_in,
    output logic                   smp_valid_out,
    output logic      [31:0]       smp_ch1_out,
    output logic      [31:0]       smp_ch2_out
);

    // Wider buses would alias the map, narrower ones cannot reach the mixer words
    if (ADDR_W < 9 || ADDR_W > 10)
        $error("bqm_top: ADDR_W must be 9 or 10");

    typedef struct packed {
        bqm_state_type    state;
        logic [1:0]       lvl;
        logic [1:0]       nlv;
        logic [1:0]       alloc;
        logic [1:0]       channel_average_sel;
        logic [3:0][31:0] mix;
        logic [1:0][31:0] cap;
        logic [31:0]      out1;
        logic [31:0]      out2;
        logic             vout;
        logic             ack;
        logic [31:0]      rdata;
    } bqm_top_state_type;

    bqm_top_state_type r;
    bqm_top_state_type next_r;

    logic [7:0]            word;
    logic                  is_coef;
    logic                  is_mix;
    logic [2:0]            coef_sec;
    logic [BQM_CIDX_W-1:0] coef_idx;
    logic                  bus_req;
    logic                  bus_wr;
    logic [31:0]           sec_rd [BQM_NSEC];
    logic [31:0]           sec_y  [BQM_NSEC];
    logic [BQM_NSEC-1:0]   sec_we;
    logic [BQM_NSEC-1:0]   sec_step;
    logic [1:0][31:0]      lvl_in;
    logic                  accept;

    assign word     = 8'(avs_address_in >> 2);
    assign is_coef  = word >= BQM_W_COEF_LO && word <= BQM_W_COEF_HI
                      && coef_idx < BQM_CIDX_W'(BQM_NCOEF);
    assign is_mix   = word >= BQM_W_MIX_LO && word <= BQM_W_MIX_HI;
    assign coef_sec = 3'((word - BQM_W_COEF_LO) >> 3);
    assign coef_idx = avs_address_in[4:2];
    assign bus_req  = avs_read_in || avs_write_in;
    assign bus_wr   = avs_write_in && r.ack;
    assign accept   = smp_valid_in && smp_ready_out;

    // Stage input: captured samples for the first level, previous level otherwise
    always_comb
    begin
        logic [2:0] prev;
        prev = {r.lvl - 2'h1, 1'b0};
        if (r.lvl == 2'h0)
            lvl_in = r.cap;
        else
            lvl_in = {sec_y[prev + 3'h1], sec_y[prev]};
    end

    for (genvar s = 0; s < BQM_NSEC; s++)
    begin : g_sec
        assign sec_step[s] = r.state == BQM_ST_FILT && r.lvl == 2'(s / 2) && r.lvl < r.nlv;
        assign sec_we[s]   = bus_wr && is_coef && coef_sec == 3'(s);

        bqm_section u_sec (
            .ref_clk_in   (ref_clk_in),
            .srst_in      (srst_in),
            .coef_we_in   (sec_we[s]),
            .coef_idx_in  (coef_idx),
            .coef_data_in (bqm_merge(sec_rd[s], avs_writedata_in, avs_byteenable_in)),
            .coef_rd_out  (sec_rd[s]),
            .step_in      (sec_step[s]),
            .x_in         (lvl_in[s % 2]),
            .y_out        (sec_y[s])
        );
    end

    always_comb
    begin
        logic [31:0] ctrl_word;
        logic [32:0] sum;
        logic [31:0] avg;
        logic [31:0] m1;
        logic [31:0] m2;
        logic [1:0]  mix_i;
        logic signed [63:0] pa;
        logic signed [63:0] pb;
        logic signed [63:0] pc;
        logic signed [63:0] pd;
        // Full 64-bit products first, so no partial product is cut to 32 bits
        pa          = $signed(lvl_in[0]) * $signed(r.mix[0]);
        pb          = $signed(lvl_in[1]) * $signed(r.mix[1]);
        pc          = $signed(lvl_in[0]) * $signed(r.mix[2]);
        pd          = $signed(lvl_in[1]) * $signed(r.mix[3]);
        next_r      = r;
        next_r.vout = 1'b0;
        ctrl_word   = '0;
        ctrl_word[BQM_CTRL_ALLOC_LSB +: 2] = r.alloc;
        ctrl_word[BQM_CTRL_AVG_LSB +: 2]   = r.channel_average_sel;
        mix_i       = word[1:0];

        // One wait state: a read is sampled on the edge where waitrequest is high, a write is taken on the edge where it is low
        next_r.ack = bus_req && !r.ack;
        if (avs_read_in && !r.ack)
        begin
            if (word == BQM_W_CTRL)
                next_r.rdata = ctrl_word;
            else if (word == BQM_W_STATUS)
                next_r.rdata = {28'h0000000, r.lvl, 1'b0, r.state != BQM_ST_IDLE};
            else if (is_coef)
                next_r.rdata = sec_rd[coef_sec];
            else if (is_mix)
                next_r.rdata = r.mix[mix_i];
            else
                next_r.rdata = '0;
        end
        if (bus_wr && word == BQM_W_CTRL)
        begin
            ctrl_word = bqm_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
            next_r.alloc               = ctrl_word[BQM_CTRL_ALLOC_LSB +: 2];
            next_r.channel_average_sel = ctrl_word[BQM_CTRL_AVG_LSB +: 2];
        end
        if (bus_wr && is_mix)
            next_r.mix[mix_i] = bqm_merge(r.mix[mix_i], avs_writedata_in, avs_byteenable_in);

        m1 = bqm_sat(BQM_ACC_W'(pa) + BQM_ACC_W'(pb));
        m2 = bqm_sat(BQM_ACC_W'(pc) + BQM_ACC_W'(pd));
        sum = ($signed({lvl_in[0][31], lvl_in[0]}) + $signed({lvl_in[1][31], lvl_in[1]})) >>> 1;
        avg = sum[31:0];

        case (r.state)
            BQM_ST_IDLE:
            begin
                if (smp_valid_in)
                begin
                    // Level count frozen per frame so a control write cannot tear a frame
                    next_r.cap   = {smp_ch2_in, smp_ch1_in};
                    next_r.lvl   = 2'h0;
                    next_r.nlv   = r.alloc;
                    next_r.state = BQM_ST_FILT;
                end
            end
            BQM_ST_FILT:
            begin
                if (r.lvl < r.nlv)
                    next_r.lvl = r.lvl + 2'h1;
                else
                begin
                    if (r.channel_average_sel != BQM_AVG_RST)
                    begin
                        next_r.out1 = avg;
                        next_r.out2 = avg;
                    end
                    else
                    begin
                        next_r.out1 = m1;
                        next_r.out2 = m2;
                    end
                    next_r.vout  = 1'b1;
                    next_r.state = BQM_ST_IDLE;
                end
            end
            default:
                next_r.state = BQM_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            r                     <= '0;
            r.state               <= BQM_ST_IDLE;
            r.alloc               <= BQM_ALLOC_RST;
            r.channel_average_sel <= BQM_AVG_RST;
            r.mix                 <= BQM_MIX_RST;
        end
        else
            r <= next_r;
    end

    assign avs_waitrequest_out = bus_req && !r.ack;
    assign avs_readdata_out    = r.rdata;
    assign smp_ready_out       = r.state == BQM_ST_IDLE;
    assign smp_valid_out       = r.vout;
    assign smp_ch1_out         = r.out1;
    assign smp_ch2_out         = r.out2;

    default clocking bqm_top_cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    AST_BYPASS_LATENCY: assert property (
        accept && r.alloc == 2'h0 |-> !smp_valid_out ##1 !smp_valid_out ##1 smp_valid_out)
        else $error("bypass frame not delivered two cycles after acceptance");

    AST_ONE_LEVEL: assert property (
        accept && r.alloc == 2'h1 |-> ##1 sec_step[0] && sec_step[1] ##1 !(|sec_step) ##1
        smp_valid_out)
        else $error("single-level frame timing wrong");

    AST_TWO_LEVELS: assert property (
        accept && r.alloc == 2'h2 |-> ##1 sec_step[1:0] == 2'h3 ##1 sec_step[3:2] == 2'h3
        ##2 smp_valid_out)
        else $error("two-level frame did not run sections 1,2 then 5,6");

    AST_THREE_LEVELS: assert property (
        accept && r.alloc == 2'h3 |-> ##3 sec_step[5:4] == 2'h3 ##2 smp_valid_out)
        else $error("three-level frame did not reach sections 9,10");

    AST_MAX_SECTIONS: assert property (
        $countones(sec_step) <= 2 && (sec_step[5:4] == 2'h0 || r.nlv == 2'h3))
        else $error("more than the usable sections active");

    AST_CASCADE_FEED: assert property (
        sec_step[2] |-> lvl_in[0] == sec_y[0] && $past(sec_step[0]))
        else $error("second section not fed by the first");

    AST_SUM_EQUAL: assert property (
        r.state == BQM_ST_FILT && r.lvl == r.nlv && r.channel_average_sel != 2'h0
        |=> smp_valid_out && smp_ch1_out == smp_ch2_out)
        else $error("summing mode outputs differ");

    AST_MUTE: assert property (
        r.state == BQM_ST_FILT && r.lvl == r.nlv && r.channel_average_sel == 2'h0
        && r.mix[0] == BQM_ZERO && r.mix[1] == BQM_ZERO |=> smp_ch1_out == BQM_ZERO)
        else $error("muted mixer produced non-zero output");

    AST_BUS_ANSWER: assert property (
        $rose(bus_req) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("bus request not answered after one wait state");

    COV_THREE_LEVELS: cover property (accept && r.alloc == 2'h3 ##5 smp_valid_out);
    COV_SUM_MODE: cover property (smp_valid_out && r.channel_average_sel == BQM_AVG_SUM);
    COV_MIX_INVERT: cover property (smp_valid_out && r.mix[1][31]);

endmodule // bqm_top

// ---- test/test_biquad_bank_channel_mixer.sv ----
`timescale 1ns/1ps
module test_biquad_bank_channel_mixer;
    import bqm_pkg::*;

    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [9:0]         adr = '0;
    logic               rd = 1'b0;
    logic               wr = 1'b0;
    logic [31:0]        wd = '0;
    logic [3:0]         be = '0;
    logic [31:0]        rdat;
    logic               wreq;
    logic               vin = 1'b0;
    logic               rdy;
    logic [31:0]        x1 = '0;
    logic [31:0]        x2 = '0;
    logic               vout;
    logic [31:0]        y1;
    logic [31:0]        y2;
    logic [31:0]        q;
    int                 failures = 0;
    int                 n_tests = 0;
    int                 alloc = 2;
    int                 avg = 0;
    logic signed [31:0] cf [6][5];
    logic signed [31:0] hx1 [6];
    logic signed [31:0] hx2 [6];
    logic signed [31:0] hy1 [6];
    logic signed [31:0] hy2 [6];
    logic signed [31:0] mix [4];
    logic [31:0]        gain [6];

    always #10 clk = ~clk;

    bqm_top #(.ADDR_W(10)) dut (
        .ref_clk_in          (clk),
        .srst_in             (rst),
        .avs_address_in      (adr),
        .avs_read_in         (rd),
        .avs_write_in        (wr),
        .avs_writedata_in    (wd),
        .avs_byteenable_in   (be),
        .avs_readdata_out    (rdat),
        .avs_waitrequest_out (wreq),
        .smp_valid_in        (vin),
        .smp_ready_out       (rdy),
        .smp_ch1_in          (x1),
        .smp_ch2_in          (x2),
        .smp_valid_out       (vout),
        .smp_ch1_out         (y1),
        .smp_ch2_out         (y2)
    );

    task automatic close_out;
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic fail_now;
        failures++;
        close_out();
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp(got, exp);
    endtask

    task automatic chk_smp(input logic [31:0] g1, g2, e1, e2);
        cmp(g1, e1);
        cmp(g2, e2);
    endtask

    task automatic chk_lat(input int got, input int exp);
        cmp(32'(got), 32'(exp));
    endtask

    // Master holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= b;
        do
        begin
            @(posedge clk);
            q = rdat;
            n++;
            if (n > 20)
                fail_now();
        end
        while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000, 4'hF);
        chk_reg(q, exp);
    endtask

    task automatic setc(input int s, input int c, input logic [31:0] v);
        bus(1'b1, 10'h080 + 10'(32 * s + 4 * c), v, 4'hF);
        cf[s][c] = v;
    endtask

    task automatic setm(input int k, input logic [31:0] v);
        bus(1'b1, 10'h140 + 10'(4 * k), v, 4'hF);
        mix[k] = v;
    endtask

    task automatic setctl(input int al, input int av);
        bus(1'b1, 10'h000, {28'h0000000, 2'(av), 2'(al)}, 4'hF);
        alloc = al;
        avg = av;
    endtask

    // Rounded 1.31 rescale, clipped to the 32-bit range
    function automatic logic signed [31:0] sat(input logic signed [67:0] acc);
        logic signed [67:0] t;
        t = (acc + 68'sh40000000) >>> 31;
        if (t > 68'sh7FFFFFFF)
            return 32'h7FFFFFFF;
        if (t < -68'sh80000000)
            return 32'h80000000;
        return t[31:0];
    endfunction

    function automatic logic signed [31:0] sec(input int s, input logic signed [31:0] x);
        logic signed [67:0] acc;
        logic signed [31:0] y;
        acc = cf[s][0] * x + 2 * cf[s][1] * hx1[s] + cf[s][2] * hx2[s]
            + 2 * cf[s][3] * hy1[s] + cf[s][4] * hy2[s];
        y = sat(acc);
        hx2[s] = hx1[s];
        hx1[s] = x;
        hy2[s] = hy1[s];
        hy1[s] = y;
        return y;
    endfunction

    function automatic logic [31:0] rs(input int bits);
        logic [31:0] r;
        r = $urandom;
        return 32'($signed(r) >>> (32 - bits));
    endfunction

    task automatic frame(input logic [31:0] a, input logic [31:0] b);
        logic signed [31:0] f1;
        logic signed [31:0] f2;
        logic signed [31:0] e1;
        logic signed [31:0] e2;
        logic signed [67:0] acc;
        int                 n;
        f1 = a;
        f2 = b;
        for (int k = 0; k < alloc; k++)
        begin
            f1 = sec(2 * k, f1);
            f2 = sec(2 * k + 1, f2);
        end
        if (avg != 0)
        begin
            acc = (f1 + f2) >>> 1;
            e1 = acc[31:0];
            e2 = acc[31:0];
        end
        else
        begin
            acc = mix[0] * f1 + mix[1] * f2;
            e1 = sat(acc);
            acc = mix[2] * f1 + mix[3] * f2;
            e2 = sat(acc);
        end
        @(posedge clk);
        vin <= 1'b1;
        x1 <= a;
        x2 <= b;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (n > 20)
                fail_now();
        end
        while (rdy !== 1'b1);
        vin <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (n > 20)
                fail_now();
        end
        while (vout !== 1'b1);
        chk_lat(n, alloc + 2);
        chk_smp(y1, y2, e1, e2);
    endtask

    initial
    begin
        void'($urandom(32'hCD50));
        for (int s = 0; s < 6; s++)
        begin
            for (int c = 0; c < 5; c++)
                cf[s][c] = (c == 0) ? 32'h7FFFFFFF : 32'h00000000;
            hx1[s] = '0;
            hx2[s] = '0;
            hy1[s] = '0;
            hy2[s] = '0;
        end
        mix = '{32'h7FFFFFFF, 32'h00000000, 32'h00000000, 32'h7FFFFFFF};
        gain = '{32'h7FFFFFFF, 32'h00000000, 32'h40000000, 32'hC0000000,
                 32'h80000001, rs(32)};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(10'h000, 32'h00000002);
        for (int s = 0; s < 6; s++)
            for (int c = 0; c < 5; c++)
                rdchk(10'h080 + 10'(32 * s + 4 * c), cf[s][c]);
        for (int k = 0; k < 4; k++)
            rdchk(10'h140 + 10'(4 * k), mix[k]);
        // Unmapped space ignores writes and reads back zero
        bus(1'b1, 10'h3FC, 32'hFFFFFFFF, 4'hF);
        rdchk(10'h3FC, 32'h00000000);
        bus(1'b1, 10'h080, 32'h12345678, 4'h3);
        rdchk(10'h080, 32'h7FFF5678);
        setc(0, 0, 32'h7FFFFFFF);
        repeat (4) frame(rs(30), rs(30));
        for (int s = 0; s < 6; s++)
            for (int c = 0; c < 5; c++)
                setc(s, c, rs(29));
        for (int al = 0; al < 4; al++)
        begin
            setctl(al, 0);
            repeat (3) frame(rs(30), rs(30));
        end
        // Mixer gains rotated over all four slots; bypass keeps values exact
        setctl(0, 0);
        for (int i = 0; i < 6; i++)
        begin
            for (int k = 0; k < 4; k++)
                setm(k, gain[(i + k) % 6]);
            frame(rs(32), rs(32));
        end
        for (int k = 0; k < 4; k++)
            setm(k, 32'h7FFFFFFF);
        frame(32'h7FFFFFFF, 32'h7FFFFFFF);
        frame(32'h80000000, 32'h80000000);
        setctl(1, 0);
        setc(0, 0, 32'h7FFFFFFF);
        setc(0, 1, 32'h7FFFFFFF);
        repeat (2) frame(32'h70000000, 32'h10000000);
        // Summing overrides the non-default mixer set above
        for (int av = 1; av < 4; av++)
        begin
            setctl(0, av);
            frame(rs(32) & 32'hFFFFFFFE, rs(32) & 32'hFFFFFFFE);
        end
        setctl(0, 0);
        for (int k = 0; k < 3; k++)
            setm(k, 32'h00000000);
        frame(rs(30), rs(30));
        setm(0, 32'h7FFFFFFF);
        frame(rs(30), rs(30));
        close_out();
    end

endmodule // test_biquad_bank_channel_mixer
